//--- dv/sfrd_array_read_test.sv
/* bench for sfrd_array_read: host model frames, array model, checks.
   assumes the checker and host model compile first. */
`timescale 1ns/1ns
`default_nettype none
module sfrd_array_read_test;
  logic        clk_in, rst_in, qe;
  int          oe_cycles, oe_mark;
  logic        si_o, si_oe, so_o, so_oe, wp_o, wp_oe, hd_o, hd_oe, busy, sclk, cs_n, hsi;
  logic [20:0] ma;
  int          num_errors = 0, num_checks = 0;
  // released so, wp and hold lines show the inverse of their last level; a released si line shows the host drive
  wire si_ln = si_oe ? si_o : hsi;
  wire so_ln = so_oe ? so_o : ~so_o;
  wire wp_ln = wp_oe ? wp_o : ~wp_o;
  wire hd_ln = hd_oe ? hd_o : ~hd_o;
  function automatic logic [7:0] mem(logic [20:0] a);
    return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
  endfunction
  sfrd_array_read i_sfrd_array_read (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .si_in(si_ln), .si_out(si_o), .si_oe_out(si_oe), .so_out(so_o),
    .so_oe_out(so_oe), .wp_n_out(wp_o), .wp_n_oe_out(wp_oe), .hold_n_out(hd_o),
    .hold_n_oe_out(hd_oe), .quad_enable_bit_in(qe), .mem_addr_out(ma),
    .mem_data_in(mem(ma)), .busy_out(busy));
  sfrd_host i_sfrd_host (.clk_in(clk_in), .so_in(so_ln), .si_ln_in(si_ln), .wp_in(wp_ln),
    .hold_in(hd_ln), .sclk_out(sclk), .cs_n_out(cs_n), .si_out(hsi));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // counts clocks with any line driven; tasks compare against a mark
  always @(posedge clk_in) begin
    if (rst_in) oe_cycles <= 0;
    else if (si_oe | so_oe | wp_oe | hd_oe) oe_cycles <= oe_cycles + 1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n, input int nc);
    oe_mark = oe_cycles;
    i_sfrd_host.run(op, a, nc);
    chk(i_sfrd_host.got.size(), n);
    chk(ma, 21'(a[20:0] + 21'(n)));
    foreach (i_sfrd_host.got[i]) chk(i_sfrd_host.got[i], mem(a[20:0] + 21'(i)));
  endtask
  task automatic t_single;
    frame(8'h03, 24'h000123, 3, 24);
    frame(8'h0b, 24'h0abc01, 2, 16);
  endtask
  task automatic t_wrap;
    frame(8'h0b, 24'h1ffffe, 4, 32);
  endtask
  task automatic t_dual;
    frame(8'h3b, 24'h1fffff, 3, 12);
  endtask
  // gated quad and unknown opcodes leave every line undriven
  task automatic t_refuse;
    logic [7:0] ops [3] = '{8'h6b, 8'h5a, 8'h02};
    qe = 1'b0;
    foreach (ops[i]) begin
      oe_mark = oe_cycles;
      i_sfrd_host.run(ops[i], 24'h000010, 8);
      chk(oe_cycles - oe_mark, 0);
    end
  endtask
  task automatic t_abort;
    qe = 1'b1;
    frame(8'h6b, 24'h000200, 1, 3);
    chk({si_oe, so_oe, wp_oe, hd_oe}, 4'h0);
    chk(busy, 1'b0);
  endtask
  task automatic t_quad;
    frame(8'h6b, 24'h054321, 4, 8);
    chk(oe_cycles > oe_mark, 1'b1);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    rst_in = 1'b1;
    qe = 1'b0;
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    t_single;
    t_wrap;
    t_dual;
    t_refuse;
    t_abort;
    t_quad;
    tally_and_finish;
  end
endmodule
bind sfrd_array_read sfrd_asserts i_sfrd_asserts (.clk_in(clk_in), .rst_in(rst_in),
  .sclk_in(sclk_in), .cs_n_in(cs_n_in), .si_in(si_in), .si_out(si_out), .si_oe_out(si_oe_out),
  .so_out(so_out), .so_oe_out(so_oe_out), .wp_n_out(wp_n_out), .wp_n_oe_out(wp_n_oe_out),
  .hold_n_out(hold_n_out), .hold_n_oe_out(hold_n_oe_out), .busy_out(busy_out),
  .quad_enable_bit_in(quad_enable_bit_in), .mem_addr_out(mem_addr_out),
  .mem_data_in(mem_data_in));
`default_nettype wire

//--- dv/sfrd_asserts.sv
/* port checker for sfrd_array_read.
   assumes a bind from the test top and a sclk far slower than clk_in. */
`timescale 1ns/1ns
`default_nettype none
module sfrd_asserts (
  input wire logic        clk_in, rst_in, sclk_in, cs_n_in, si_in,
  input wire logic        si_out, si_oe_out, so_out, so_oe_out, wp_n_out, wp_n_oe_out,
  input wire logic        hold_n_out, hold_n_oe_out, quad_enable_bit_in, busy_out,
  input wire logic [20:0] mem_addr_out,
  input wire logic [7:0]  mem_data_in
);
  logic       sc_q;
  logic [5:0] rise_q;
  wire        any_oe = si_oe_out | so_oe_out | wp_n_oe_out | hold_n_oe_out;
  // raw rises lead the design's synchronised view, so this errs safe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sc_q <= 1'b0;
      rise_q <= 6'h0;
    end else begin
      sc_q <= sclk_in;
      if (cs_n_in)
        rise_q <= 6'h0;
      else if (sclk_in && !sc_q && rise_q < 6'h20)
        rise_q <= rise_q + 6'h1;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_reset_idle:
    assert property (disable iff (1'b0) rst_in |-> !any_oe && mem_addr_out == 21'h0)
    else $error("not idle in reset");
  a_cs_release:
    assert property (cs_n_in [*6] |-> !any_oe) else $error("line driven after cs high");
  a_no_early_drive:
    assert property (!cs_n_in && rise_q < 6'h20 |-> !any_oe) else $error("early drive");
  a_quad_group:
    assert property (hold_n_oe_out |-> wp_n_oe_out && si_oe_out && so_oe_out)
    else $error("quad lines split");
  a_dual_group:
    assert property (si_oe_out |-> so_oe_out) else $error("si driven without so");
  a_quad_gate:
    assert property (!quad_enable_bit_in [*8] |-> !hold_n_oe_out) else $error("quad ungated");
  a_addr_step:
    assert property (so_oe_out && $past(so_oe_out) && mem_addr_out != $past(mem_addr_out)
      |-> mem_addr_out == $past(mem_addr_out) + 21'h1) else $error("address jump");
  a_data_stand:
    assert property (sclk_in [*5] |-> $stable({so_out, si_out, wp_n_out, hold_n_out}))
    else $error("data moved while sclk high");
  a_busy_on:
    assert property (!cs_n_in [*3] |-> busy_out) else $error("busy low while selected");
  a_busy_off:
    assert property (cs_n_in [*3] |-> !busy_out) else $error("busy high while deselected");
  c_quad: cover property (hold_n_oe_out);
  c_dual: cover property (si_oe_out && !hold_n_oe_out);
  c_wrap: cover property (mem_addr_out == 21'h0 && $past(mem_addr_out) == 21'h1fffff);
endmodule
`default_nettype wire

//--- dv/sfrd_host.sv
/* host spi model: mode 0 frames of opcode, address, dummy, data.
   assumes the bench resolves the shared io lines. */
`timescale 1ns/1ns
`default_nettype none
module sfrd_host (
  input  wire logic clk_in,
  input  wire logic so_in, si_ln_in, wp_in, hold_in,
  output var  logic sclk_out, cs_n_out, si_out
);
  logic [7:0] got [$];
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  task automatic half;
    repeat (8) @(negedge clk_in);
  endtask
  task automatic run(input logic [7:0] op, input logic [23:0] a, input int nclk);
    int ln, dm, k;
    logic [31:0] sh;
    logic [7:0] acc;
    logic [3:0] nb;
    ln = op == 8'h3b ? 2 : op == 8'h6b ? 4 : 1;
    dm = op == 8'h03 ? 32 : 40;
    sh = {op, a};
    got.delete();
    k = 0;
    acc = 8'h0;
    cs_n_out = 1'b0;
    half;
    for (int i = 0; i < dm + nclk; i++) begin
      si_out = i < 32 ? sh[31] : ~si_out;
      sh = sh << 1;
      half;
      nb = ln == 1 ? {3'h0, so_in} : ln == 2 ? {2'h0, so_in, si_ln_in} : {hold_in, wp_in, so_in, si_ln_in};
      sclk_out = 1'b1;
      if (i >= dm) begin
        acc = (acc << ln) | 8'(nb);
        k++;
        if (k * ln % 8 == 0) got.push_back(acc);
      end
      half;
      sclk_out = 1'b0;
    end
    cs_n_out = 1'b1;
    repeat (16) @(negedge clk_in);
  endtask
endmodule
`default_nettype wire

//--- include/sfrd_regs.vh
/*
  constants for the serial flash array read path: opcodes, phase lengths,
  array size. assumes inclusion by bare name from the rtl file.
*/
`ifndef SFRD_REGS_VH
`define SFRD_REGS_VH
`define SFRD_OP_READ       8'h03
`define SFRD_OP_FAST_READ  8'h0b
`define SFRD_OP_DUAL_READ  8'h3b
`define SFRD_OP_QUAD_READ  8'h6b
`define SFRD_OPCODE_BITS   6'd8
`define SFRD_ADDR_BITS     6'd24
`define SFRD_DUMMY_BITS    6'd8
`define SFRD_ADDR_TOP      21'h1fffff
`define SFRD_ADDR_W        21
`endif

//--- rtl/sfrd_array_read.v
/*
  read path of a serial flash: single, dual and quad output array reads.
  assumes spi mode 0 (sample on rising sclk, change on falling), the link
  pins sampled by clk_in which must run well above twice the sclk rate,
  and array data served combinationally from an external store on
  mem_addr_out / mem_data_in in the clk_in domain.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sfrd_regs.vh"

module sfrd_array_read (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // link pins
  input  wire        sclk_in,
  input  wire        cs_n_in,
  input  wire        si_in,
  output reg         si_out,
  output reg         si_oe_out,
  output reg         so_out,
  output reg         so_oe_out,
  output reg         wp_n_out,
  output reg         wp_n_oe_out,
  output reg         hold_n_out,
  output reg         hold_n_oe_out,
  // configuration
  input  wire        quad_enable_bit_in,
  // array port
  output wire [20:0] mem_addr_out,
  input  wire [7:0]  mem_data_in,
  // status
  output wire        busy_out
);
  localparam [4:0] ST_OPC   = 5'b00001;
  localparam [4:0] ST_ADDR  = 5'b00010;
  localparam [4:0] ST_DUMMY = 5'b00100;
  localparam [4:0] ST_DATA  = 5'b01000;
  localparam [4:0] ST_IGN   = 5'b10000;
  localparam [1:0] MODE_1   = 2'd0;
  localparam [1:0] MODE_2   = 2'd1;
  localparam [1:0] MODE_4   = 2'd2;

  // two-stage synchronisers
  reg  [2:0]  sync1_q;
  reg  [2:0]  sync2_q;
  reg         sclk_prev_q;
  reg         qe_sync1_q;
  reg         qe_sync2_q;
  wire        sclk_s   = sync2_q[0];
  wire        cs_n_s   = sync2_q[1];
  wire        si_s     = sync2_q[2];
  wire        rise     = sclk_s & ~sclk_prev_q & ~cs_n_s;
  wire        fall     = ~sclk_s & sclk_prev_q & ~cs_n_s;

  reg  [4:0]  state_q;
  reg  [5:0]  bit_cnt_q;
  reg  [7:0]  shift_q;
  reg  [23:0] addr_sh_q;
  reg  [1:0]  mode_q;
  reg         has_dummy_q;
  reg  [`SFRD_ADDR_W-1:0] addr_q;
  reg  [7:0]  byte_q;
  reg  [2:0]  slot_q;
  reg         first_q;
  wire [7:0]  opc_next = {shift_q[6:0], si_s};
  wire [23:0] addr_next = {addr_sh_q[22:0], si_s};
  wire [2:0]  slot_last = (mode_q == MODE_1) ? 3'd7 :
                          (mode_q == MODE_2) ? 3'd3 : 3'd1;

  assign mem_addr_out = addr_q;
  assign busy_out     = ~cs_n_s;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      // idle pin levels, so no false sclk edge or select follows reset
      sync1_q     <= 3'h2;
      sync2_q     <= 3'h2;
      sclk_prev_q <= 1'b0;
      qe_sync1_q  <= 1'b0;
      qe_sync2_q  <= 1'b0;
    end else begin
      sync1_q     <= {si_in, cs_n_in, sclk_in};
      sync2_q     <= sync1_q;
      sclk_prev_q <= sclk_s;
      qe_sync1_q  <= quad_enable_bit_in;
      qe_sync2_q  <= qe_sync1_q;
    end
  end

  // command sequencer
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q     <= ST_OPC;
      bit_cnt_q   <= 6'h00;
      shift_q     <= 8'h00;
      addr_sh_q   <= 24'h000000;
      mode_q      <= MODE_1;
      has_dummy_q <= 1'b0;
      addr_q      <= {`SFRD_ADDR_W{1'b0}};
    end else if (cs_n_s) begin
      state_q   <= ST_OPC;
      bit_cnt_q <= 6'h00;
    end else if (rise) begin
      case (state_q)
        ST_OPC: begin
          shift_q   <= opc_next;
          bit_cnt_q <= bit_cnt_q + 6'd1;
          if (bit_cnt_q == `SFRD_OPCODE_BITS - 6'd1) begin
            bit_cnt_q <= 6'h00;
            state_q   <= ST_ADDR;
            if (opc_next == `SFRD_OP_READ) begin
              mode_q      <= MODE_1;
              has_dummy_q <= 1'b0;
            end else if (opc_next == `SFRD_OP_FAST_READ) begin
              mode_q      <= MODE_1;
              has_dummy_q <= 1'b1;
            end else if (opc_next == `SFRD_OP_DUAL_READ) begin
              mode_q      <= MODE_2;
              has_dummy_q <= 1'b1;
            end else if (opc_next == `SFRD_OP_QUAD_READ && qe_sync2_q) begin
              mode_q      <= MODE_4;
              has_dummy_q <= 1'b1;
            end else begin
              // unknown or refused opcode: stay silent
              state_q <= ST_IGN;
            end
          end
        end
        ST_ADDR: begin
          addr_sh_q <= addr_next;
          bit_cnt_q <= bit_cnt_q + 6'd1;
          if (bit_cnt_q == `SFRD_ADDR_BITS - 6'd1) begin
            bit_cnt_q <= 6'h00;
            addr_q    <= addr_next[`SFRD_ADDR_W-1:0];
            state_q   <= has_dummy_q ? ST_DUMMY : ST_DATA;
          end
        end
        ST_DUMMY: begin
          bit_cnt_q <= bit_cnt_q + 6'd1;
          if (bit_cnt_q == `SFRD_DUMMY_BITS - 6'd1) begin
            bit_cnt_q <= 6'h00;
            state_q   <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (slot_q == slot_last) begin
            addr_q <= (addr_q == `SFRD_ADDR_TOP) ? {`SFRD_ADDR_W{1'b0}} :
                      addr_q + 21'd1;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // output shifter, updates on falling sclk
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      byte_q        <= 8'h00;
      slot_q        <= 3'd0;
      first_q       <= 1'b1;
      si_out        <= 1'b0;
      so_out        <= 1'b0;
      wp_n_out      <= 1'b0;
      hold_n_out    <= 1'b0;
      si_oe_out     <= 1'b0;
      so_oe_out     <= 1'b0;
      wp_n_oe_out   <= 1'b0;
      hold_n_oe_out <= 1'b0;
    end else if (cs_n_s || state_q != ST_DATA) begin
      first_q       <= 1'b1;
      slot_q        <= 3'd0;
      si_oe_out     <= 1'b0;
      so_oe_out     <= 1'b0;
      wp_n_oe_out   <= 1'b0;
      hold_n_oe_out <= 1'b0;
    end else if (fall) begin
      // new byte on first slot, else shift on
      if (first_q || slot_q == slot_last) begin
        byte_q  <= mem_data_in;
        slot_q  <= first_q ? 3'd0 : 3'd0;
        first_q <= 1'b0;
      end else begin
        slot_q <= slot_q + 3'd1;
      end
      case (mode_q)
        MODE_2: begin
          si_oe_out <= 1'b1;
          so_oe_out <= 1'b1;
          if (first_q || slot_q == slot_last) begin
            so_out <= mem_data_in[7];
            si_out <= mem_data_in[6];
            byte_q <= {mem_data_in[5:0], 2'b00};
          end else begin
            so_out <= byte_q[7];
            si_out <= byte_q[6];
            byte_q <= {byte_q[5:0], 2'b00};
          end
        end
        MODE_4: begin
          si_oe_out     <= 1'b1;
          so_oe_out     <= 1'b1;
          wp_n_oe_out   <= 1'b1;
          hold_n_oe_out <= 1'b1;
          if (first_q || slot_q == slot_last) begin
            {hold_n_out, wp_n_out, so_out, si_out} <= mem_data_in[7:4];
            byte_q <= {mem_data_in[3:0], 4'h0};
          end else begin
            {hold_n_out, wp_n_out, so_out, si_out} <= byte_q[7:4];
            byte_q <= {byte_q[3:0], 4'h0};
          end
        end
        default: begin
          so_oe_out <= 1'b1;
          if (first_q || slot_q == slot_last) begin
            so_out <= mem_data_in[7];
            byte_q <= {mem_data_in[6:0], 1'b0};
          end else begin
            so_out <= byte_q[7];
            byte_q <= {byte_q[6:0], 1'b0};
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire
